/* rtl/interrupt_source_map.sv */
`timescale 1ns/1ps
module interrupt_source_map
    import irq_map_pkg::*;
#(
    parameter logic [NUM_REQ-1:0] PRESENT_MASK = {NUM_REQ{1'b1}}
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [NUM_REQ-1:0] sourceReq,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irqValid,
    output logic [VEC_W-1:0] irqVector,
    output logic [REQ_W-1:0] irqRequest,
    output logic [PRI_W-1:0] irqPriority,
    output logic [SUB_W-1:0] irqSubPriority
);

    // =====================================================================
    // state
    logic [NUM_REQ-1:0] flags;
    logic [NUM_REQ-1:0] enables;
    logic [NUM_REQ-1:0] srcPrev;
    logic [31:0] prio [0:NUM_PRIO_REGS-1];

    // =====================================================================
    // bus decode
    wire logic access = psel && penable;
    wire logic commit = access && pready;
    wire logic doWrite = commit && pwrite;
    wire logic selFlagLo = (paddr == OFS_FLAG_LO);
    wire logic selFlagHi = (paddr == OFS_FLAG_HI);
    wire logic selEnLo = (paddr == OFS_EN_LO);
    wire logic selEnHi = (paddr == OFS_EN_HI);
    wire logic selPrio = (paddr >= OFS_PRIO_BASE) && (paddr <= OFS_PRIO_LAST)
        && (paddr[1:0] == 2'h0);
    wire logic selActive = (paddr == OFS_ACTIVE);
    wire logic [2:0] prioIdx = 3'((paddr - OFS_PRIO_BASE) >> 2);
    wire logic mapped = selFlagLo || selFlagHi || selEnLo || selEnHi || selPrio
        || selActive;

    // word n/32, bit n%32 for each request
    wire logic [2*FLAG_REG_W-1:0] flagsWide = {{(2*FLAG_REG_W-NUM_REQ){1'b0}}, flags};
    wire logic [2*FLAG_REG_W-1:0] enWide = {{(2*FLAG_REG_W-NUM_REQ){1'b0}}, enables};
    wire logic [NUM_REQ-1:0] wrData = {pwdata[FLAGS_HI_W-1:0], pwdata};
    wire logic [NUM_REQ-1:0] wrLoMask = {{FLAGS_HI_W{1'b0}}, {FLAG_REG_W{1'b1}}};
    wire logic [NUM_REQ-1:0] wrHiMask = ~wrLoMask;

    wire logic [31:0] activeWord = {10'h000, irqValid, irqPriority, irqSubPriority,
        irqRequest, 5'h00, irqVector};
    wire logic [31:0] readMux =
        selFlagLo ? flagsWide[FLAG_REG_W-1:0] :
        selFlagHi ? flagsWide[2*FLAG_REG_W-1:FLAG_REG_W] :
        selEnLo ? enWide[FLAG_REG_W-1:0] :
        selEnHi ? enWide[2*FLAG_REG_W-1:FLAG_REG_W] :
        selPrio ? prio[prioIdx] :
        selActive ? activeWord : RST_WORD;

    // =====================================================================
    // source events: persistent sources re-set the flag while held,
    // the others only on a rising edge so a stuck line cannot retrigger
    wire logic [NUM_REQ-1:0] rise = sourceReq & ~srcPrev;
    wire logic [NUM_REQ-1:0] hwSet = ((sourceReq & REQ_PERSISTENT)
        | (rise & ~REQ_PERSISTENT)) & PRESENT_MASK;

    wire logic [NUM_REQ-1:0] swMask = doWrite ? ((selFlagLo ? wrLoMask : '0)
        | (selFlagHi ? wrHiMask : '0)) : '0;
    wire logic [NUM_REQ-1:0] enMask = doWrite ? ((selEnLo ? wrLoMask : '0)
        | (selEnHi ? wrHiMask : '0)) : '0;

    // set wins over a software clear in the same cycle
    wire logic [NUM_REQ-1:0] next_flags =
        (((flags & ~swMask) | (wrData & swMask)) | hwSet) & PRESENT_MASK;
    wire logic [NUM_REQ-1:0] next_enables =
        ((enables & ~enMask) | (wrData & enMask)) & PRESENT_MASK;

    // =====================================================================
    // arbitration over all requests
    logic [NUM_REQ-1:0] eligible;
    logic [PRI_W+SUB_W-1:0] reqLevel [0:NUM_REQ-1];
    logic found;
    logic [PRI_W+SUB_W-1:0] bestLevel;
    logic [REQ_W-1:0] bestReq;

    always_comb begin
        for (int i = 0; i < NUM_REQ; i++) begin
            // slot vec%4 of register vec/4; shared vectors share a slot
            reqLevel[i] = prio[REQ_VECTOR[i][VEC_W-1:2]][REQ_VECTOR[i][1:0]*SLOT_STRIDE
                +: PRI_W+SUB_W];
            eligible[i] = flags[i] && enables[i]
                && (reqLevel[i][PRI_W+SUB_W-1:PRI_LSB] != '0);
        end
    end

    always_comb begin
        found = 1'b0;
        bestLevel = '0;
        bestReq = '0;
        // walk downward so that on a tie the lower number is kept
        for (int i = NUM_REQ - 1; i >= 0; i--) begin
            if (eligible[i] && (!found || reqLevel[i] >= bestLevel)) begin
                found = 1'b1;
                bestLevel = reqLevel[i];
                bestReq = REQ_W'(i);
            end
        end
    end

    // =====================================================================
    // registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flags <= '0;
            enables <= '0;
            srcPrev <= '0;
        end else begin
            flags <= next_flags;
            enables <= next_enables;
            srcPrev <= sourceReq;
        end
    end

    always_ff @(posedge sys_clk) begin
        for (int r = 0; r < NUM_PRIO_REGS; r++) begin
            if (sys_rst) begin
                prio[r] <= RST_WORD;
            end else if (doWrite && selPrio && prioIdx == 3'(r)) begin
                prio[r] <= pwdata & PRIO_IMPL_MASK;
            end
        end
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RST_WORD;
        end else begin
            pready <= access && !pready;
            pslverr <= access && !pready && !mapped;
            prdata <= (access && !pready && !pwrite) ? readMux : RST_WORD;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irqValid <= 1'b0;
            irqVector <= '0;
            irqRequest <= '0;
            irqPriority <= '0;
            irqSubPriority <= '0;
        end else begin
            irqValid <= found;
            irqVector <= found ? REQ_VECTOR[bestReq] : '0;
            irqRequest <= bestReq;
            irqPriority <= bestLevel[PRI_W+SUB_W-1:PRI_LSB];
            irqSubPriority <= bestLevel[PRI_LSB-1:SUB_LSB];
        end
    end

    // =====================================================================
    // checks
    property p_tie_low;
        @(posedge sys_clk) disable iff (sys_rst)
        (eligible == 39'h0000000060 && reqLevel[5] == reqLevel[6])
            |=> (irqRequest == 6'h05);
    endproperty
    a_tie_low: assert property (p_tie_low) else $error("tie not won by lower number");

    property p_tick;
        @(posedge sys_clk) disable iff (sys_rst)
        (eligible == 39'h0000000001) |=> (irqValid && irqVector == 5'h00);
    endproperty
    a_tick: assert property (p_tick) else $error("core tick vector wrong");

    property p_soft;
        @(posedge sys_clk) disable iff (sys_rst)
        (eligible == 39'h0000000004) |=> (irqVector == 5'h02 && irqRequest == 6'h02);
    endproperty
    a_soft: assert property (p_soft) else $error("soft request vector wrong");

    property p_pin;
        @(posedge sys_clk) disable iff (sys_rst)
        (eligible == 39'h0000800000) |=> (irqVector == 5'h13);
    endproperty
    a_pin: assert property (p_pin) else $error("external pin vector wrong");

    property p_capture_persist;
        @(posedge sys_clk) disable iff (sys_rst)
        (sourceReq[6] && PRESENT_MASK[6]) |=> flags[6];
    endproperty
    a_capture_persist: assert property (p_capture_persist) else $error("capture flag lost");

    property p_compare_edge;
        @(posedge sys_clk) disable iff (sys_rst)
        (srcPrev[7] && sourceReq[7] && !flags[7] && !swMask[7]) |=> !flags[7];
    endproperty
    a_compare_edge: assert property (p_compare_edge) else $error("level retriggered");

    property p_adc;
        @(posedge sys_clk) disable iff (sys_rst)
        (eligible == 39'h0010000000) |=> (irqVector == 5'h17 && irqRequest == 6'h1c);
    endproperty
    a_adc: assert property (p_adc) else $error("converter vector wrong");

    property p_flash_bit;
        @(posedge sys_clk) disable iff (sys_rst)
        (rise[31] && PRESENT_MASK[31]) |=> flagsWide[31];
    endproperty
    a_flash_bit: assert property (p_flash_bit) else $error("flash flag not at bit 31");

    property p_cmp;
        @(posedge sys_clk) disable iff (sys_rst)
        (rise[32] && PRESENT_MASK[32]) |=> flagsWide[FLAG_REG_W];
    endproperty
    a_cmp: assert property (p_cmp) else $error("comparator flag misplaced");

    property p_spi_shared;
        @(posedge sys_clk) disable iff (sys_rst)
        (eligible == 39'h2000000000) |=> (irqVector == 5'h1f);
    endproperty
    a_spi_shared: assert property (p_spi_shared) else $error("serial vector wrong");

    property p_cap2;
        @(posedge sys_clk) disable iff (sys_rst)
        (eligible == 39'h0000000800) |=> (irqVector == 5'h09);
    endproperty
    a_cap2: assert property (p_cap2) else $error("capture2 vector wrong");

    property p_absent;
        @(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> ((flags & ~PRESENT_MASK) == '0) && ((enables & ~PRESENT_MASK) == '0);
    endproperty
    a_absent: assert property (p_absent) else $error("absent source flag set");

    property p_pready_pulse;
        @(posedge sys_clk) disable iff (sys_rst)
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready held too long");

    property p_pready_wait;
        @(posedge sys_clk) disable iff (sys_rst)
        (access && !pready) |=> pready;
    endproperty
    a_pready_wait: assert property (p_pready_wait) else $error("access not answered");

    property p_err_unmapped;
        @(posedge sys_clk) disable iff (sys_rst)
        (access && !pready && !mapped) |=> (pslverr && pready);
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

    property p_err_mapped;
        @(posedge sys_clk) disable iff (sys_rst)
        (access && !pready && mapped) |=> !pslverr;
    endproperty
    a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");

    property p_en_lo_write;
        @(posedge sys_clk) disable iff (sys_rst)
        (doWrite && selEnLo) |=> (enables[FLAG_REG_W-1:0]
            == ($past(pwdata) & PRESENT_MASK[FLAG_REG_W-1:0]));
    endproperty
    a_en_lo_write: assert property (p_en_lo_write) else $error("low enable word");

    property p_en_hi_write;
        @(posedge sys_clk) disable iff (sys_rst)
        (doWrite && selEnHi) |=> (enables[NUM_REQ-1:FLAG_REG_W]
            == ($past(pwdata[FLAGS_HI_W-1:0]) & PRESENT_MASK[NUM_REQ-1:FLAG_REG_W]));
    endproperty
    a_en_hi_write: assert property (p_en_hi_write) else $error("high enable word");

    property p_prio_write;
        @(posedge sys_clk) disable iff (sys_rst)
        (doWrite && selPrio && prioIdx == 3'h0)
            |=> (prio[0] == ($past(pwdata) & PRIO_IMPL_MASK));
    endproperty
    a_prio_write: assert property (p_prio_write) else $error("priority word");

    property p_soft_slot;
        @(posedge sys_clk) disable iff (sys_rst)
        (reqLevel[1] == prio[0][12:8]) && (reqLevel[2] == prio[0][20:16]);
    endproperty
    a_soft_slot: assert property (p_soft_slot) else $error("soft slot");

    property p_pin_slot;
        @(posedge sys_clk) disable iff (sys_rst)
        (reqLevel[3] == prio[0][28:24]) && (reqLevel[8] == prio[1][28:24])
            && (reqLevel[13] == prio[2][28:24]) && (reqLevel[18] == prio[3][28:24])
            && (reqLevel[23] == prio[4][28:24]);
    endproperty
    a_pin_slot: assert property (p_pin_slot) else $error("pin slot");

    property p_cap1_slot;
        @(posedge sys_clk) disable iff (sys_rst)
        (reqLevel[5] == prio[1][12:8]) && (reqLevel[6] == reqLevel[5]);
    endproperty
    a_cap1_slot: assert property (p_cap1_slot) else $error("capture1 slot");

    property p_compare_slot;
        @(posedge sys_clk) disable iff (sys_rst)
        (reqLevel[7] == prio[1][20:16]) && (reqLevel[12] == prio[2][20:16])
            && (reqLevel[17] == prio[3][20:16]) && (reqLevel[22] == prio[4][20:16])
            && (reqLevel[27] == prio[5][20:16]);
    endproperty
    a_compare_slot: assert property (p_compare_slot) else $error("compare slot");

    property p_serial_slot;
        @(posedge sys_clk) disable iff (sys_rst)
        (reqLevel[36] == prio[7][28:24]) && (reqLevel[37] == reqLevel[36])
            && (reqLevel[38] == reqLevel[36]);
    endproperty
    a_serial_slot: assert property (p_serial_slot) else $error("serial slot");

    property p_cap2_slot;
        @(posedge sys_clk) disable iff (sys_rst)
        (reqLevel[10] == prio[2][12:8]) && (reqLevel[11] == reqLevel[10]);
    endproperty
    a_cap2_slot: assert property (p_cap2_slot) else $error("capture2 slot");

    property p_clkfail_vec;
        @(posedge sys_clk) disable iff (sys_rst)
        (eligible == 39'h0020000000) |=> (irqVector == 5'h18 && irqRequest == 6'h1d);
    endproperty
    a_clkfail_vec: assert property (p_clkfail_vec) else $error("clock failure vector");

    property p_calendar_vec;
        @(posedge sys_clk) disable iff (sys_rst)
        (eligible == 39'h0040000000) |=> (irqVector == 5'h19 && irqRequest == 6'h1e);
    endproperty
    a_calendar_vec: assert property (p_calendar_vec) else $error("calendar vector");

    property p_flash_vec;
        @(posedge sys_clk) disable iff (sys_rst)
        (eligible == 39'h0080000000) |=> (irqVector == 5'h1a && irqRequest == 6'h1f);
    endproperty
    a_flash_vec: assert property (p_flash_vec) else $error("flash vector");

    property p_comp2_vec;
        @(posedge sys_clk) disable iff (sys_rst)
        (eligible == 39'h0200000000) |=> (irqVector == 5'h1c && irqRequest == 6'h21);
    endproperty
    a_comp2_vec: assert property (p_comp2_vec) else $error("comparator2 vector");

    property p_usb_vec;
        @(posedge sys_clk) disable iff (sys_rst)
        (eligible == 39'h0800000000) |=> (irqVector == 5'h1e && irqRequest == 6'h23);
    endproperty
    a_usb_vec: assert property (p_usb_vec) else $error("usb vector");

    property p_usb_persist;
        @(posedge sys_clk) disable iff (sys_rst)
        (sourceReq[35] && PRESENT_MASK[35]) |=> flags[35];
    endproperty
    a_usb_persist: assert property (p_usb_persist) else $error("usb flag lost");

endmodule : interrupt_source_map

/* rtl/irq_map_pkg.sv */
package irq_map_pkg;

    // =====================================================================
    // sizes
    localparam int NUM_REQ = 39;
    localparam int REQ_W = 6;
    localparam int VEC_W = 5;
    localparam int PRI_W = 3;
    localparam int SUB_W = 2;
    localparam int NUM_PRIO_REGS = 8;
    localparam int FLAG_REG_W = 32;
    localparam int FLAGS_HI_W = NUM_REQ - FLAG_REG_W;

    // =====================================================================
    // priority register slot layout
    localparam int SLOT_STRIDE = 8;
    localparam int SUB_LSB = 0;
    localparam int PRI_LSB = 2;
    localparam logic [31:0] PRIO_IMPL_MASK = 32'h1f1f1f1f;

    // =====================================================================
    // register byte offsets
    localparam logic [7:0] OFS_FLAG_LO = 8'h00;
    localparam logic [7:0] OFS_FLAG_HI = 8'h04;
    localparam logic [7:0] OFS_EN_LO = 8'h08;
    localparam logic [7:0] OFS_EN_HI = 8'h0c;
    localparam logic [7:0] OFS_PRIO_BASE = 8'h10;
    localparam logic [7:0] OFS_PRIO_LAST = 8'h2c;
    localparam logic [7:0] OFS_ACTIVE = 8'h30;

    // =====================================================================
    // reset values
    localparam logic [31:0] RST_WORD = 32'h00000000;

    // =====================================================================
    // request number to vector number
    localparam logic [VEC_W-1:0] REQ_VECTOR [0:NUM_REQ-1] = '{
        5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h05, 5'h06,
        5'h07, 5'h08, 5'h09, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d,
        5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h11, 5'h12, 5'h13,
        5'h14, 5'h15, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1a,
        5'h1b, 5'h1c, 5'h1d, 5'h1e, 5'h1f, 5'h1f, 5'h1f};

    // persistent requests are level driven, the rest are edge driven
    localparam logic [NUM_REQ-1:0] REQ_PERSISTENT = 39'h7816318c60;

endpackage : irq_map_pkg

/* verification/irq_source_model.sv */
`timescale 1ns/1ps
// =========================================
// peripheral event sources
module irq_source_model
    import irq_map_pkg::*;
(
    input wire logic sys_clk,
    input wire logic fire,
    input wire logic hold,
    input wire logic [NUM_REQ-1:0] mask,
    output logic [NUM_REQ-1:0] sourceReq
);
    // a pattern drops after one cycle unless held, so edge sources see a single event
    always_ff @(posedge sys_clk) begin
        if (fire)
            sourceReq <= mask;
        else if (!hold)
            sourceReq <= '0;
    end
endmodule : irq_source_model

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
    import irq_map_pkg::*;
    // =========================================
    // wiring
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic fire = 1'b0;
    logic hold = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irqValid, err;
    logic [VEC_W-1:0] irqVector;
    logic [REQ_W-1:0] irqRequest;
    logic [PRI_W-1:0] irqPriority;
    logic [SUB_W-1:0] irqSubPriority;
    logic [NUM_REQ-1:0] sourceReq;
    logic [NUM_REQ-1:0] mask = '0;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    // request 9 is built absent: its neighbours must keep their places
    localparam logic [NUM_REQ-1:0] PRESENT = ~(39'h1 << 9);
    localparam logic [NUM_REQ-1:0] PERSIST = 39'h7816318c60;
    localparam int SHARED [7] = '{6, 11, 16, 21, 26, 37, 38};

    interrupt_source_map #(.PRESENT_MASK(PRESENT)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .sourceReq(sourceReq), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irqValid(irqValid), .irqVector(irqVector), .irqRequest(irqRequest),
        .irqPriority(irqPriority), .irqSubPriority(irqSubPriority));
    irq_source_model SRC (.sys_clk(sys_clk), .fire(fire), .hold(hold), .mask(mask),
        .sourceReq(sourceReq));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    // =========================================
    // helpers
    function automatic int vec_of(int n);
        vec_of = n;
        foreach (SHARED[i]) if (n >= SHARED[i]) vec_of--;
    endfunction : vec_of

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no own limit: a slave that never answers is caught by the cycle ceiling
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pulse(input logic [NUM_REQ-1:0] m, input logic h);
        @(posedge sys_clk);
        mask <= m;
        fire <= 1'b1;
        hold <= h;
        @(posedge sys_clk);
        fire <= 1'b0;
    endtask : pulse

    // =========================================
    // scenarios
    task automatic t_reset();
        for (int a = 0; a <= 48; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            chk(rd, 32'h0);
            chk(err, 32'h0);
        end
        apb(1'b0, 8'h34, 32'h0);
        chk(err, 32'h1);
    endtask : t_reset

    task automatic t_map();
        int n, v, w;
        logic [7:0] pa;
        for (n = 0; n < NUM_REQ; n++) begin
            v = vec_of(n);
            w = n / 32;
            pa = 8'(OFS_PRIO_BASE + 4 * (v / 4));
            apb(1'b1, pa, 32'({3'(1 + n % 7), 2'(n % 4)}) << (8 * (v % 4)));
            pulse(39'h1 << n, 1'b1);
            apb(1'b0, 8'(4 * w), 32'h0);
            chk(rd, PRESENT[n] ? 32'h1 << (n % 32) : 32'h0);
            chk(irqValid, PRESENT[n]);
            if (PRESENT[n]) begin
                chk({irqVector, irqRequest}, {5'(v), 6'(n)});
                chk({irqPriority, irqSubPriority}, {3'(1 + n % 7), 2'(n % 4)});
            end
            apb(1'b1, 8'(4 * w), 32'h0);
            apb(1'b0, 8'(4 * w), 32'h0);
            chk(rd, PRESENT[n] && PERSIST[n] ? 32'h1 << (n % 32) : 32'h0);
            hold <= 1'b0;
            apb(1'b1, 8'(4 * w), 32'h0);
            apb(1'b1, pa, 32'h0);
        end
    endtask : t_map

    task automatic t_order();
        int k;
        int firsts [5] = '{0, 1, 5, 10, 36};
        for (int i = 0; i < NUM_PRIO_REGS; i++) begin
            apb(1'b1, 8'(OFS_PRIO_BASE + 4 * i), '1);
            apb(1'b0, 8'(OFS_PRIO_BASE + 4 * i), 32'h0);
            chk(rd, 32'h1f1f1f1f);
        end
        pulse('1, 1'b0);
        foreach (firsts[j]) begin
            k = firsts[j];
            apb(1'b1, OFS_FLAG_LO, k < 32 ? 32'hffffffff << k : 32'h0);
            apb(1'b1, OFS_FLAG_HI, k < 32 ? 32'h7f : 32'h7f << (k - 32));
            apb(1'b0, OFS_FLAG_LO, 32'h0);
            chk(rd, k < 32 ? (32'hffffffff << k) & PRESENT[31:0] : 32'h0);
            chk({irqRequest, irqVector}, {6'(k), 5'(vec_of(k))});
        end
        apb(1'b0, OFS_ACTIVE, 32'h0);
        chk(rd, {10'h0, 1'b1, 3'h7, 2'h3, 6'h24, 5'h0, 5'h1f});
        apb(1'b1, OFS_EN_HI, 32'h0);
        apb(1'b0, OFS_ACTIVE, 32'h0);
        chk(rd, 32'h0);
        chk(irqValid, 32'h0);
        // only the two capture1 requests left, same slot: the lower number must win
        apb(1'b1, OFS_FLAG_LO, 32'h60);
        apb(1'b0, OFS_ACTIVE, 32'h0);
        chk(rd, {10'h0, 1'b1, 3'h7, 2'h3, 6'h05, 5'h0, 5'h05});
    endtask : t_order

    initial begin
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        apb(1'b1, OFS_EN_LO, 32'hffffffff);
        apb(1'b1, OFS_EN_HI, 32'h7f);
        t_map();
        t_order();
        close_out();
    end
endmodule : tb
